// >>> src/rtcai_pkg.sv
// Notes on behaviour
// RULE1 - Alarm field bit 7 arms that field.
// RULE2 - Armed alarm fields compare against current time.
// RULE3 - Alarm interrupt enable is bit 0 at 01h.
// RULE4 - First full match with enable sets alarm flag.
// RULE5 - Alarm flag and pin hold until written 0.
// RULE6 - Re-set only on a fresh match after advance.
// RULE7 - Unimplemented enable and flag bits read 0.
// RULE8 - Interrupt pin is active-low open-drain.
// RULE9 - Pin ORs five flags gated by their enables.
// RULE10 - Countdown enable bit 1 gates flag bit 1.
// RULE11 - Clearing alarm or countdown flag releases pin immediately.
// RULE12 - Low-voltage A needs flag and status cleared.
// RULE13 - Low-voltage B needs flag and status cleared.
// RULE14 - System reset needs flag and status cleared.
// RULE15 - Watch enable gates tick, set after reset.
// RULE16 - Watch stopped: counters loadable, no advance.
// RULE17 - Watch enable leaves square wave alone.
// RULE18 - Unkicked recovery counter fires within two scans.
// RULE19 - Control bit 4 enables recovery, default on.
// RULE20 - Recovery reloads control registers, keeps time.
// RULE21 - Recovery reset sets system reset flag.
// RULE22 - Scan period bit selects 1 or 16 s.
// RULE23 - Writing 1 to a flag changes nothing.
package rtcai_pkg;
   localparam int ALM_FIELDS = 7;
   localparam int ALM_EN_BIT = 7;
   localparam int ALM_VAL_MSB = 6;
   localparam int IRQ_SRC = 5;
   localparam int IRQ_ALARM = 0;
   localparam int IRQ_COUNT = 1;
   localparam int IRQ_LVA = 2;
   localparam int IRQ_LVB = 3;
   localparam int IRQ_SYS = 4;
   localparam int CTRL1_WATCH_EN_BIT = 0;
   localparam int CTRL1_RECOV_EN_BIT = 4;
   localparam int EE_THERMO_SCAN_BIT = 0;
   localparam logic [7:0] ADDR_CTRL1 = 8'h00;
   localparam logic [7:0] ADDR_INT_EN = 8'h01;
   localparam logic [7:0] ADDR_INT_FLAG = 8'h02;
   localparam logic [7:0] ADDR_STATUS = 8'h03;
   localparam logic [7:0] ADDR_ALM_BASE = 8'h10;
   localparam logic [7:0] ADDR_EE_CTRL = 8'h30;
   localparam logic [7:0] CTRL1_RESET = 8'h11;
   localparam logic [7:0] EE_CTRL_RESET = 8'h00;
   localparam logic [7:0] ALM_RESET = 8'h00;
   localparam logic [IRQ_SRC-1:0] INT_EN_RESET = 5'h00;
   localparam logic [IRQ_SRC-1:0] FLAG_RESET = 5'h00;
   localparam logic [IRQ_SRC-1:0] STATUS_RESET = 5'h00;
   localparam int SCAN_SHORT_S = 1;
   localparam int SCAN_LONG_S = 16;
   localparam int RECOV_SCAN_PERIODS = 2;
   localparam int RECOV_CNT_W = 6;
   localparam logic [RECOV_CNT_W-1:0] RECOV_LIMIT_SHORT = RECOV_CNT_W'(RECOV_SCAN_PERIODS * SCAN_SHORT_S);
   localparam logic [RECOV_CNT_W-1:0] RECOV_LIMIT_LONG = RECOV_CNT_W'(RECOV_SCAN_PERIODS * SCAN_LONG_S);
   localparam logic [RECOV_CNT_W-1:0] RECOV_CNT_ONE = 6'h01;

   typedef logic [ALM_FIELDS-1:0][7:0] rtcai_fields_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } rtcai_reg_req_t;

   typedef enum logic [2:0] {
      RECOV_IDLE = 3'b001,
      RECOV_COUNT = 3'b010,
      RECOV_FIRE = 3'b100
   } rtcai_recov_state_t;
endpackage

// >>> src/rtcai_alarm_cmp.sv
`timescale 1ns/100ps
module rtcai_alarm_cmp
   import rtcai_pkg::*;
(
   input wire rtcai_fields_t alarm_regs,
   input wire rtcai_fields_t cur_time,
   output logic match
);
   logic [ALM_FIELDS-1:0] hit;
   logic [ALM_FIELDS-1:0] armed;

   // One comparator per field; a disarmed field never blocks the match.
   for (genvar i = 0; i < ALM_FIELDS; i++) begin : g_field
      assign armed[i] = alarm_regs[i][ALM_EN_BIT]; // [RULE1]
      assign hit[i] = !armed[i] || (alarm_regs[i][ALM_VAL_MSB:0] == cur_time[i][ALM_VAL_MSB:0]); // [RULE2]
   end

   // With nothing armed there is no alarm, rather than a match on every second.
   assign match = (&hit) && (|armed); // [RULE1]
endmodule

// >>> src/rtcai_self_recovery.sv
`timescale 1ns/100ps
module rtcai_self_recovery
   import rtcai_pkg::*;
(
   input wire ref_clk,
   input wire resetn,
   input wire enable,
   input wire long_scan,
   input wire tick_1hz,
   input wire kick,
   output logic fire
);
   rtcai_recov_state_t state_ff;
   rtcai_recov_state_t nxt_state;
   logic [RECOV_CNT_W-1:0] cnt_ff;
   logic [RECOV_CNT_W-1:0] nxt_cnt;
   logic [RECOV_CNT_W-1:0] limit;

   // Timeout is two scan intervals; the first tick may be partial, so the reset comes at the latest then.
   assign limit = long_scan ? RECOV_LIMIT_LONG : RECOV_LIMIT_SHORT; // [RULE18] [RULE22]

   // Watchdog sequencing: count whole seconds since the last kick.
   always_comb begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      case (state_ff)
         RECOV_IDLE: begin
            nxt_cnt = '0;
            if (enable) nxt_state = RECOV_COUNT; // [RULE19]
         end
         RECOV_COUNT: begin
            if (!enable) begin
               nxt_state = RECOV_IDLE;
               nxt_cnt = '0;
            end else if (kick) begin
               nxt_cnt = '0;
            end else if (tick_1hz) begin
               if (cnt_ff + RECOV_CNT_ONE >= limit) begin
                  nxt_state = RECOV_FIRE; // [RULE18]
                  nxt_cnt = '0;
               end else begin
                  nxt_cnt = cnt_ff + RECOV_CNT_ONE;
               end
            end
         end
         RECOV_FIRE: nxt_state = RECOV_COUNT;
         default: begin
            nxt_state = RECOV_IDLE;
            nxt_cnt = '0;
         end
      endcase
   end

   // State and counter registers.
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         state_ff <= RECOV_IDLE;
         cnt_ff <= '0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
      end
   end

   assign fire = (state_ff == RECOV_FIRE);

   chk_recov_bound: assert property (@(posedge ref_clk) disable iff (!resetn) // [RULE18]
      (state_ff == RECOV_COUNT) |-> (cnt_ff < limit))
      else $error("Recovery counter passed its limit.");
endmodule

// >>> src/rtcai_top.sv
`timescale 1ns/100ps
module rtcai_top
   import rtcai_pkg::*;
(
   input wire ref_clk,
   input wire resetn,
   input wire rtcai_reg_req_t reg_req,
   output logic [7:0] reg_rdata,
   input wire rtcai_fields_t cur_time,
   input wire time_advance,
   input wire tick_1hz,
   input wire countdown_event,
   input wire low_voltage_a,
   input wire low_voltage_b,
   input wire sys_reset_req,
   input wire recov_kick,
   input wire irq_n_i,
   output logic irq_n_o,
   output logic irq_n_oe,
   output logic watch_tick,
   output logic [7:0] ctrl1_out,
   output logic thermo_scan_period,
   output logic recovery_reset
);
   logic [7:0] ctrl1_ff;
   logic [7:0] nxt_ctrl1;
   logic [7:0] ee_ctrl_ff;
   logic [IRQ_SRC-1:0] int_en_ff;
   logic [IRQ_SRC-1:0] nxt_int_en;
   logic [IRQ_SRC-1:0] flags_ff;
   logic [IRQ_SRC-1:0] nxt_flags;
   logic [IRQ_SRC-1:0] status_ff;
   logic [IRQ_SRC-1:0] nxt_status;
   logic [IRQ_SRC-1:0] flag_set;
   logic [IRQ_SRC-1:0] flag_clr;
   logic [IRQ_SRC-1:0] status_set;
   logic [IRQ_SRC-1:0] status_clr;
   logic [IRQ_SRC-1:0] nxt_src;
   logic [IRQ_SRC-1:0] cur_src;
   rtcai_fields_t alarm_ff;
   logic alarm_match;
   logic match_seen_ff;
   logic alarm_set;
   logic recov_fire;
   logic ctl_reload;
   logic wr_ctrl1;
   logic wr_int_en;
   logic wr_flag;
   logic wr_status;
   logic wr_ee;
   logic [7:0] rd_val;
   logic irq_n_oe_ff;
   logic watch_tick_ff;
   logic irq_n_o_ff;
   logic [7:0] rdata_ff;
   logic recovery_reset_ff;

   // Register write strobes, one per implemented address outside the alarm bytes, which decode their own writes below.
   assign wr_ctrl1 = reg_req.wr && (reg_req.addr == ADDR_CTRL1);
   assign wr_int_en = reg_req.wr && (reg_req.addr == ADDR_INT_EN);
   assign wr_flag = reg_req.wr && (reg_req.addr == ADDR_INT_FLAG);
   assign wr_status = reg_req.wr && (reg_req.addr == ADDR_STATUS);
   assign wr_ee = reg_req.wr && (reg_req.addr == ADDR_EE_CTRL);

   // Either reset source restarts the control page, never the time or alarm pages.
   assign ctl_reload = sys_reset_req || recov_fire; // [RULE20]

   // Alarm comparison across all seven fields.
   rtcai_alarm_cmp u_alarm_cmp (
      .alarm_regs(alarm_ff),
      .cur_time(cur_time),
      .match(alarm_match)
   );

   // Deadlock watchdog, counting seconds from the free-running tick.
   rtcai_self_recovery u_recovery (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .enable(ctrl1_ff[CTRL1_RECOV_EN_BIT]), // [RULE19]
      .long_scan(ee_ctrl_ff[EE_THERMO_SCAN_BIT]), // [RULE22]
      .tick_1hz(tick_1hz),
      .kick(recov_kick),
      .fire(recov_fire)
   );

   // First control register; power-up and recovery both load watch and recovery enables set.
   always_comb begin
      nxt_ctrl1 = ctrl1_ff;
      if (ctl_reload) begin
         nxt_ctrl1 = CTRL1_RESET; // [RULE15] [RULE19] [RULE20]
      end else if (wr_ctrl1) begin
         nxt_ctrl1 = reg_req.wdata;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         ctrl1_ff <= CTRL1_RESET; // [RULE15] [RULE19]
      end else begin
         ctrl1_ff <= nxt_ctrl1;
      end
   end

   // Interrupt enable register; only five bits exist, so the upper three cannot hold a value.
   always_comb begin
      nxt_int_en = int_en_ff;
      if (ctl_reload) begin
         nxt_int_en = INT_EN_RESET; // [RULE20]
      end else if (wr_int_en) begin
         nxt_int_en = reg_req.wdata[IRQ_SRC-1:0]; // [RULE3] [RULE7]
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         int_en_ff <= INT_EN_RESET;
      end else begin
         int_en_ff <= nxt_int_en;
      end
   end

   // Thermometer control is not a control-page register, so recovery leaves it alone.
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         ee_ctrl_ff <= EE_CTRL_RESET;
      end else if (wr_ee) begin
         ee_ctrl_ff <= reg_req.wdata;
      end
   end

   // Alarm registers survive recovery; only power-up clears them.
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         for (int i = 0; i < ALM_FIELDS; i++) begin
            alarm_ff[i] <= ALM_RESET;
         end
      end else begin
         for (int i = 0; i < ALM_FIELDS; i++) begin
            if (reg_req.wr && (reg_req.addr == ADDR_ALM_BASE + 8'(i))) begin
               alarm_ff[i] <= reg_req.wdata; // [RULE20]
            end
         end
      end
   end

   // The match is only looked at when the time steps, so a lasting match fires once.
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         match_seen_ff <= 1'b0;
      end else if (time_advance) begin
         match_seen_ff <= alarm_match; // [RULE6]
      end
   end

   assign alarm_set = time_advance && alarm_match && !match_seen_ff && int_en_ff[IRQ_ALARM]; // [RULE4] [RULE6]

   // Hardware events that raise the interrupt flags.
   always_comb begin
      flag_set = '0;
      flag_set[IRQ_ALARM] = alarm_set; // [RULE3] [RULE4]
      flag_set[IRQ_COUNT] = countdown_event && int_en_ff[IRQ_COUNT]; // [RULE10]
      flag_set[IRQ_LVA] = low_voltage_a && int_en_ff[IRQ_LVA]; // [RULE12]
      flag_set[IRQ_LVB] = low_voltage_b && int_en_ff[IRQ_LVB]; // [RULE13]
      flag_set[IRQ_SYS] = ctl_reload; // [RULE21]
   end

   // Writing a 0 clears a flag and writing a 1 is a no-op; a same-cycle event still wins.
   assign flag_clr = wr_flag ? ~reg_req.wdata[IRQ_SRC-1:0] : '0; // [RULE5] [RULE23]

   always_comb begin
      if (ctl_reload) begin
         nxt_flags = FLAG_RESET | flag_set; // [RULE20] [RULE21]
      end else begin
         nxt_flags = (flags_ff & ~flag_clr) | flag_set; // [RULE5] [RULE23]
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         flags_ff <= FLAG_RESET;
      end else begin
         flags_ff <= nxt_flags;
      end
   end

   // Status bits record the detector and reset events regardless of the enables.
   always_comb begin
      status_set = '0;
      status_set[IRQ_LVA] = low_voltage_a;
      status_set[IRQ_LVB] = low_voltage_b;
      status_set[IRQ_SYS] = ctl_reload;
   end

   assign status_clr = wr_status ? ~reg_req.wdata[IRQ_SRC-1:0] : '0;

   always_comb begin
      if (ctl_reload) begin
         nxt_status = STATUS_RESET | status_set;
      end else begin
         nxt_status = (status_ff & ~status_clr) | status_set;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         status_ff <= STATUS_RESET;
      end else begin
         status_ff <= nxt_status;
      end
   end

   // The pin state is built from next values so a clearing write releases it on the same edge.
   always_comb begin
      nxt_src = '0;
      nxt_src[IRQ_ALARM] = nxt_int_en[IRQ_ALARM] && nxt_flags[IRQ_ALARM]; // [RULE9] [RULE11]
      nxt_src[IRQ_COUNT] = nxt_int_en[IRQ_COUNT] && nxt_flags[IRQ_COUNT]; // [RULE10] [RULE11]
      nxt_src[IRQ_LVA] = nxt_int_en[IRQ_LVA] && (nxt_flags[IRQ_LVA] || nxt_status[IRQ_LVA]); // [RULE12]
      nxt_src[IRQ_LVB] = nxt_int_en[IRQ_LVB] && (nxt_flags[IRQ_LVB] || nxt_status[IRQ_LVB]); // [RULE13]
      nxt_src[IRQ_SYS] = nxt_int_en[IRQ_SYS] && (nxt_flags[IRQ_SYS] || nxt_status[IRQ_SYS]); // [RULE14]
   end

   // Open drain: the driven level is always low, and the enable goes low to pull the line.
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         irq_n_oe_ff <= 1'b1;
      end else begin
         irq_n_oe_ff <= !(|nxt_src); // [RULE8] [RULE9]
      end
   end

   // The tick to the watch counters is gated here; the square-wave path never sees this gate.
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         watch_tick_ff <= 1'b0;
      end else begin
         watch_tick_ff <= tick_1hz && ctrl1_ff[CTRL1_WATCH_EN_BIT]; // [RULE15] [RULE16] [RULE17]
      end
   end

   // Read data multiplexer; unmapped addresses and missing bits read as zero.
   always_comb begin
      rd_val = 8'h00;
      case (reg_req.addr)
         ADDR_CTRL1: rd_val = ctrl1_ff;
         ADDR_INT_EN: rd_val = 8'(int_en_ff); // [RULE7]
         ADDR_INT_FLAG: rd_val = 8'(flags_ff); // [RULE7]
         ADDR_STATUS: rd_val = 8'(status_ff);
         ADDR_EE_CTRL: rd_val = ee_ctrl_ff;
         default: begin
            for (int i = 0; i < ALM_FIELDS; i++) begin
               if (reg_req.addr == ADDR_ALM_BASE + 8'(i)) rd_val = alarm_ff[i];
            end
         end
      endcase
   end

   // Read data is registered and held until the next read.
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         rdata_ff <= 8'h00;
      end else if (reg_req.rd) begin
         rdata_ff <= rd_val;
      end
   end

   // Pulse that lets the rest of the chip restart its control logic.
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         recovery_reset_ff <= 1'b0;
      end else begin
         recovery_reset_ff <= ctl_reload;
      end
   end

   // The open-drain data bit is held low by a flop so every output leaves a register.
   always_ff @(posedge ref_clk) begin
      irq_n_o_ff <= 1'b0;
   end

   assign reg_rdata = rdata_ff;
   assign irq_n_o = irq_n_o_ff;
   assign irq_n_oe = irq_n_oe_ff;
   assign watch_tick = watch_tick_ff;
   assign ctrl1_out = ctrl1_ff;
   assign thermo_scan_period = ee_ctrl_ff[EE_THERMO_SCAN_BIT];
   assign recovery_reset = recovery_reset_ff;

   // Enabled sources as seen from the registers, for the checks below.
   assign cur_src[IRQ_ALARM] = int_en_ff[IRQ_ALARM] && flags_ff[IRQ_ALARM];
   assign cur_src[IRQ_COUNT] = int_en_ff[IRQ_COUNT] && flags_ff[IRQ_COUNT];
   assign cur_src[IRQ_SYS:IRQ_LVA] = int_en_ff[IRQ_SYS:IRQ_LVA] & (flags_ff[IRQ_SYS:IRQ_LVA] | status_ff[IRQ_SYS:IRQ_LVA]);

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   chk_alarm_cause: assert property ( // [RULE3] [RULE4] [RULE6]
      $rose(flags_ff[IRQ_ALARM]) && !$past(ctl_reload) |->
         $past(time_advance && alarm_match && !match_seen_ff && int_en_ff[IRQ_ALARM]))
      else $error("Alarm flag rose without a fresh enabled match.");

   chk_alarm_hold: assert property ( // [RULE5]
      $past(flags_ff[IRQ_ALARM]) && !$past(wr_flag && !reg_req.wdata[IRQ_ALARM]) && !$past(ctl_reload)
         |-> flags_ff[IRQ_ALARM])
      else $error("Alarm flag dropped without a clearing write.");

   chk_rsvd_zero: assert property ( // [RULE7]
      $past(reg_req.rd && (reg_req.addr == ADDR_INT_EN || reg_req.addr == ADDR_INT_FLAG))
         |-> (rdata_ff[7:IRQ_SRC] == '0))
      else $error("Unimplemented interrupt bits read nonzero.");

   chk_pin_follow: assert property ( // [RULE8] [RULE9] [RULE11]
      (irq_n_oe_ff == !(|cur_src)) && !irq_n_o)
      else $error("Interrupt pin does not follow the enabled flags.");

   chk_count_gate: assert property ( // [RULE10] [RULE23]
      !$past(flags_ff[IRQ_COUNT]) && !$past(countdown_event && int_en_ff[IRQ_COUNT]) |-> !flags_ff[IRQ_COUNT])
      else $error("Countdown flag set without an enabled event.");

   chk_lv_both: assert property ( // [RULE12] [RULE13] [RULE14]
      (int_en_ff[IRQ_LVA] && status_ff[IRQ_LVA]) || (int_en_ff[IRQ_LVB] && status_ff[IRQ_LVB])
         || (int_en_ff[IRQ_SYS] && status_ff[IRQ_SYS]) |-> !irq_n_oe_ff)
      else $error("Interrupt released while a status bit is still set.");

   chk_watch_gate: assert property ( // [RULE15] [RULE16]
      watch_tick_ff == $past(tick_1hz && ctrl1_ff[CTRL1_WATCH_EN_BIT]))
      else $error("Watch tick not gated by the watch enable.");

   chk_recov_reload: assert property ( // [RULE19] [RULE20] [RULE21]
      $past(recov_fire) |-> (ctrl1_ff == CTRL1_RESET) && flags_ff[IRQ_SYS] && status_ff[IRQ_SYS] && recovery_reset_ff)
      else $error("Recovery did not reload control and set the reset flag.");

   chk_recov_window: assert property ( // [RULE18] [RULE22]
      $rose(recov_fire) |-> $past(!recov_kick))
      else $error("Recovery fired in a kicked cycle.");

   // A reload must spare the alarm bytes and thermometer control.
   // Otherwise a recovery would silently lose a pending alarm time.
   chk_alarm_keep: assert property ( // [RULE20]
      $past(ctl_reload) && !$past(reg_req.wr) |-> (alarm_ff == $past(alarm_ff)) && (ee_ctrl_ff == $past(ee_ctrl_ff)))
      else $error("Reload disturbed the alarm or thermometer registers.");

   chk_flag_wr_one: assert property ( // [RULE23]
      $past(wr_flag) && !$past(ctl_reload) |->
         ((flags_ff & $past(flags_ff & reg_req.wdata[IRQ_SRC-1:0])) == $past(flags_ff & reg_req.wdata[IRQ_SRC-1:0])))
      else $error("Writing one to a set flag cleared it.");

   cov_alarm_irq: cover property ($rose(flags_ff[IRQ_ALARM]) ##[1:20] !irq_n_oe_ff);
   cov_alarm_clear: cover property (flags_ff[IRQ_ALARM] ##1 !flags_ff[IRQ_ALARM] ##[1:100] flags_ff[IRQ_ALARM]);
   cov_recov_fire: cover property ($rose(recov_fire));
   cov_sys_reload: cover property ($rose(recovery_reset_ff) && !$past(recov_fire));
   cov_lv_status: cover property (!flags_ff[IRQ_LVA] && status_ff[IRQ_LVA] && int_en_ff[IRQ_LVA]);
endmodule

// >>> sim/rtcai_host_model.sv
`timescale 1ns/100ps
// Host side of the register port, plus the resistor that pulls the interrupt line up.
module rtcai_host_model
   import rtcai_pkg::*;
(
   input wire ref_clk,
   input wire irq_n_o,
   input wire irq_n_oe,
   input wire [7:0] reg_rdata,
   output rtcai_reg_req_t reg_req,
   output logic irq_pin
);
   // The line floats high through the pull-up unless the device sinks it.
   assign irq_pin = irq_n_oe ? 1'b1 : irq_n_o;

   // The port starts idle.
   initial begin
      reg_req = '0;
   end

   // One strobe cycle, launched and released at falling edges.
   // Address and data are inverted afterwards so that nothing can lean on stale values.
   task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] wdata,
                         output logic [7:0] rdata);
      @(negedge ref_clk);
      reg_req = '{wr: wr, rd: ~wr, addr: addr, wdata: wdata};
      @(negedge ref_clk);
      rdata = reg_rdata;
      reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~wdata};
   endtask
endmodule

// >>> sim/rtcai_bench.sv
`timescale 1ns/100ps
// Self-checking bench for the alarm, interrupt and self-recovery block.
module rtcai_bench;
   import rtcai_pkg::*;
   localparam int TA = 0;
   localparam int TK = 1;
   localparam int CD = 2;
   localparam int SR = 5;
   localparam int KK = 6;
   logic ref_clk;
   logic resetn;
   logic [6:0] ev;
   logic irq_pin;
   logic irq_n_o;
   logic irq_n_oe;
   logic watch_tick;
   logic thermo_scan_period;
   logic recovery_reset;
   logic [7:0] reg_rdata;
   logic [7:0] ctrl1_out;
   logic aen = 1'b0;
   logic prev = 1'b0;
   rtcai_reg_req_t reg_req;
   rtcai_fields_t cur_time;
   rtcai_fields_t alm = '0;
   logic [7:0] mins [5] = '{8'h2c, 8'h2d, 8'h2d, 8'h2e, 8'h2d};
   int error_cnt = 0;
   int checks = 0;

   rtcai_host_model u_rtcai_host_model (
      .ref_clk(ref_clk),
      .irq_n_o(irq_n_o),
      .irq_n_oe(irq_n_oe),
      .reg_rdata(reg_rdata),
      .reg_req(reg_req),
      .irq_pin(irq_pin)
   );

   rtcai_top u_rtcai_top (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .reg_req(reg_req),
      .reg_rdata(reg_rdata),
      .cur_time(cur_time),
      .time_advance(ev[TA]),
      .tick_1hz(ev[TK]),
      .countdown_event(ev[CD]),
      .low_voltage_a(ev[3]),
      .low_voltage_b(ev[4]),
      .sys_reset_req(ev[SR]),
      .recov_kick(ev[KK]),
      .irq_n_i(irq_pin),
      .irq_n_o(irq_n_o),
      .irq_n_oe(irq_n_oe),
      .watch_tick(watch_tick),
      .ctrl1_out(ctrl1_out),
      .thermo_scan_period(thermo_scan_period),
      .recovery_reset(recovery_reset)
   );

   // Free-running 100 MHz clock.
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   task automatic results();
      $display("checks %0d error_cnt %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] r;
      u_rtcai_host_model.access(1'b1, a, d, r);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] r;
      u_rtcai_host_model.access(1'b0, a, 8'h00, r);
      check(r, e);
   endtask

   task automatic pin_chk(input logic e);
      check(8'(irq_pin), 8'(e));
   endtask

   // Single-cycle pulse on one of the event inputs.
   task automatic pulse(input int k);
      @(negedge ref_clk);
      ev[k] = 1'b1;
      @(negedge ref_clk);
      ev[k] = 1'b0;
   endtask

   // Bounded wait for the reload pulse; a pulse missing when expected, or seen when not, ends the run, since later steps depend on it.
   task automatic wait_rst(input int lim, input logic exp);
      int n = 0;
      while (recovery_reset !== 1'b1 && n < lim) begin
         @(negedge ref_clk);
         n++;
      end
      check(8'(recovery_reset), 8'(exp));
      if (recovery_reset !== exp) results();
   endtask

   task automatic tick(input logic kick, input logic exp_wt);
      pulse(TK);
      check(8'(watch_tick), 8'(exp_wt));
      if (kick) pulse(KK);
   endtask

   // Expected alarm match: every armed field equal on bits 6:0, and at least one field armed.
   function automatic logic exp_match(input rtcai_fields_t a, input rtcai_fields_t t);
      logic any = 1'b0;
      logic all = 1'b1;
      for (int f = 0; f < ALM_FIELDS; f++) begin
         if (a[f][ALM_EN_BIT]) begin
            any = 1'b1;
            if (a[f][ALM_VAL_MSB:0] != t[f][ALM_VAL_MSB:0]) all = 1'b0;
         end
      end
      return any & all;
   endfunction

   task automatic load_alarms();
      for (int f = 0; f < ALM_FIELDS; f++) wr(ADDR_ALM_BASE + 8'(f), alm[f]);
   endtask

   // One watch step, then the flag and pin checks and the clearing write.
   task automatic advance();
      logic m;
      logic e;
      pulse(TA);
      m = exp_match(alm, cur_time);
      e = aen & m & ~prev;
      rd_chk(ADDR_INT_FLAG, {7'h00, e});
      pin_chk(~e);
      wr(ADDR_INT_FLAG, 8'h00);
      pin_chk(1'b1);
      prev = m;
   endtask

   // Main sequence.
   initial begin
      resetn = 1'b0;
      ev = '0;
      cur_time = '0;
      void'($urandom(97985));
      repeat (16) @(negedge ref_clk);
      resetn = 1'b1;
      rd_chk(ADDR_CTRL1, CTRL1_RESET);
      rd_chk(8'h05, 8'h00);
      pin_chk(1'b1);
      check(8'(irq_n_o), 8'h00);
      wr(ADDR_INT_EN, 8'hff);
      rd_chk(ADDR_INT_EN, 8'h1f);
      wr(ADDR_INT_FLAG, 8'hff);
      rd_chk(ADDR_INT_FLAG, 8'h00);
      // Hand-written minute alarm: a held match after clearing must not set the flag again.
      aen = 1'b1;
      wr(ADDR_INT_EN, 8'h01);
      alm[1] = 8'had;
      load_alarms();
      foreach (mins[i]) begin
         cur_time[1] = mins[i];
         advance();
      end
      // Random rounds with narrow values so that matches and repeats are frequent.
      for (int r = 0; r < 6; r++) begin
         aen = r[0];
         wr(ADDR_INT_EN, {7'h00, aen});
         for (int f = 0; f < ALM_FIELDS; f++) alm[f] = {($urandom_range(0, 2) == 0), 6'h00, 1'($urandom)};
         load_alarms();
         for (int s = 0; s < 20; s++) begin
            for (int f = 0; f < ALM_FIELDS; f++) cur_time[f] = {1'($urandom), 6'h00, 1'($urandom)};
            advance();
         end
      end
      // Countdown source: dropped while disabled, unmoved by a write of one.
      wr(ADDR_INT_EN, 8'h00);
      pulse(CD);
      rd_chk(ADDR_INT_FLAG, 8'h00);
      wr(ADDR_INT_EN, 8'h02);
      pulse(CD);
      pin_chk(1'b0);
      wr(ADDR_INT_FLAG, 8'h02);
      rd_chk(ADDR_INT_FLAG, 8'h02);
      wr(ADDR_INT_FLAG, 8'h00);
      pin_chk(1'b1);
      // Low-voltage sources hold the pin until both flag and status are zeroed.
      for (int k = 2; k < 4; k++) begin
         wr(ADDR_INT_EN, 8'(1 << k));
         pulse(k + 1);
         rd_chk(ADDR_INT_FLAG, 8'(1 << k));
         rd_chk(ADDR_STATUS, 8'(1 << k));
         wr(ADDR_INT_FLAG, 8'h00);
         pin_chk(1'b0);
         wr(ADDR_STATUS, 8'h00);
         pin_chk(1'b1);
      end
      // System reset reloads control but keeps the alarm bytes.
      wr(ADDR_CTRL1, 8'h00);
      pulse(SR);
      wait_rst(6, 1'b1);
      check(ctrl1_out, CTRL1_RESET);
      rd_chk(ADDR_INT_EN, 8'h00);
      for (int f = 0; f < ALM_FIELDS; f++) rd_chk(ADDR_ALM_BASE + 8'(f), alm[f]);
      wr(ADDR_INT_EN, 8'h10);
      pin_chk(1'b0);
      wr(ADDR_INT_FLAG, 8'h00);
      pin_chk(1'b0);
      wr(ADDR_STATUS, 8'h00);
      pin_chk(1'b1);
      // Kicked ticks never fire; the watch tick follows the watch enable.
      repeat (3) tick(1'b1, 1'b1);
      wr(ADDR_CTRL1, 8'h10);
      tick(1'b1, 1'b0);
      // Short scan: the second unkicked tick fires recovery.
      tick(1'b0, 1'b0);
      wait_rst(4, 1'b0);
      tick(1'b0, 1'b0);
      wait_rst(6, 1'b1);
      check(ctrl1_out, CTRL1_RESET);
      rd_chk(ADDR_INT_FLAG, 8'h10);
      // Long scan: thirty-one ticks are tolerated, the thirty-second fires.
      wr(ADDR_EE_CTRL, 8'h01);
      check(8'(thermo_scan_period), 8'h01);
      repeat (31) tick(1'b0, 1'b1);
      wait_rst(4, 1'b0);
      tick(1'b0, 1'b1);
      wait_rst(6, 1'b1);
      // Recovery switched off: no reload however long the ticks go unkicked.
      wr(ADDR_CTRL1, 8'h01);
      repeat (40) tick(1'b0, 1'b1);
      wait_rst(4, 1'b0);
      results();
   end
endmodule
